// [design/boundary_scan_test_ops.sv]
`timescale 1ns/1ps
// Functional notes
// [R1] boundary read: boundary register in path, unchanged on capture
// [R2] self test: every cell captures its complement on capture, normal mode
// [R3] toggle outputs: bypass in path, bypass captures zero
// [R4] toggle outputs in idle: output shift stages invert on rise, shadows update on fall
// [R5] toggle outputs: input cells hold, pins not sampled, test mode
// [R6] control scan: control register in path, unchanged on capture
// [R7] controller loads the control register before a run test
// [R8] run-test operation decoded from control register bits 1:0
// [R9] operation runs only under run-test instruction in idle state
// [R10] cells 17 and 16 excluded from all run-test algorithms
// [R11] cell 16 still gates output drive during run tests
// [R12] sample/toggle: input stages sample pins on rise, shadows feed core
// [R13] sample/toggle: output stages invert on rise, shadows drive pins on fall
// [R14] pattern mode: 16-bit feedback register advances, shadows update on fall
// [R15] controller seeds the boundary register; all-zero seed stalls patterns
// [R16] signature mode: inputs folded into 16-bit signature on rise
// [R17] 16-bit signature mode: output shadows stay fixed
// [R18] combined mode: input stages compress into 8-bit signature
// [R19] combined mode: output stages run 8-bit pattern generator
// [R20] run-test instruction selects bypass, test mode, runs operation in idle
// [R21] inputs sampled on rising test clock, outputs change on falling
// [R22] maximal-length feedback polynomials chosen for both widths
// [R23] outside idle, run-test operations hold all stages and shadows
module boundary_scan_test_ops (
  input wire logic clk,
  input wire logic srst,
  input wire logic tck,
  input wire logic tdi,
  input wire logic [7:0] data_in,
  input wire logic capture_dr,
  input wire logic shift_dr,
  input wire logic update_dr,
  input wire logic run_idle,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic tdo,
  output logic [7:0] data_out,
  output logic data_out_oe,
  output logic [7:0] core_in,
  output logic test_mode
);
  localparam int unsigned W = scan_ops_pkg::BR_WIDTH;
  localparam int unsigned IL = scan_ops_pkg::IN_LSB;
  localparam int unsigned OL = scan_ops_pkg::OUT_LSB;

  // synchronisers: first stage read only by second
  logic [11:0] s1_q;
  logic [11:0] s2_q;
  logic tck_prev_q;
  always_ff @(posedge clk) begin
    if (srst) begin
      s1_q <= 12'h000;
      s2_q <= 12'h000;
      tck_prev_q <= 1'b0;
    end else begin
      s1_q <= {tck, tdi, capture_dr, shift_dr, data_in};
      s2_q <= s1_q;
      tck_prev_q <= s2_q[11];
    end
  end
  logic tck_s;
  logic tdi_s;
  logic cap_s;
  logic sh_s;
  logic [7:0] pin_s;
  assign tck_s = s2_q[11];
  assign tdi_s = s2_q[10];
  assign cap_s = s2_q[9];
  assign sh_s = s2_q[8];
  assign pin_s = s2_q[7:0];
  logic rise;
  logic fall;
  assign rise = tck_s & ~tck_prev_q; // R21
  assign fall = ~tck_s & tck_prev_q; // R21

  // level controls sampled too
  logic [1:0] l1_q;
  logic [1:0] l2_q;
  always_ff @(posedge clk) begin
    if (srst) begin
      l1_q <= 2'h0;
      l2_q <= 2'h0;
    end else begin
      l1_q <= {update_dr, run_idle};
      l2_q <= l1_q;
    end
  end
  logic upd_s;
  logic idle_s;
  assign upd_s = l2_q[1];
  assign idle_s = l2_q[0];

  // registers
  logic [scan_ops_pkg::IR_WIDTH-1:0] instr_q;
  logic [scan_ops_pkg::CR_WIDTH-1:0] ctrl_q;
  logic [W-1:0] shift_q;
  logic [W-1:0] shadow_q;
  logic bypass_q;

  logic [6:0] op;
  assign op = instr_q[6:0];
  logic sel_br;
  logic sel_cr;
  logic is_run;
  logic is_toggle;
  assign sel_br = (op == scan_ops_pkg::OP_READ_NORMAL) || (op == scan_ops_pkg::OP_READ_TEST) ||
                  (op == scan_ops_pkg::OP_CELL_TEST); // R1 R2
  assign sel_cr = (op == scan_ops_pkg::OP_CTRL_NORMAL) ||
                  (op == scan_ops_pkg::OP_CTRL_TEST); // R6
  assign is_run = (op == scan_ops_pkg::OP_RUN_TEST);
  assign is_toggle = (op == scan_ops_pkg::OP_TOGGLE);
  logic active;
  assign active = is_run && idle_s; // R9 R20 R23

  // next shift stages for run-test operations
  logic [W-1:0] run_d;
  logic [15:0] cur16;
  logic [15:0] nxt16;
  logic [7:0] in8;
  logic [7:0] out8;
  always_comb begin
    cur16 = shift_q[15:0];
    in8 = shift_q[OL-1:IL];
    out8 = shift_q[OL+7:OL];
    nxt16 = cur16;
    run_d = shift_q; // R10 cells 17:16 untouched
    case (ctrl_q) // R8
      scan_ops_pkg::RT_SAMPLE_TOGGLE: begin
        run_d[OL-1:IL] = pin_s; // R12
        run_d[OL+7:OL] = ~out8; // R13
      end
      scan_ops_pkg::RT_PATTERN16: begin
        nxt16 = {cur16[14:0], ^(cur16 & scan_ops_pkg::POLY16)}; // R14 R22
        run_d[15:0] = nxt16;
      end
      scan_ops_pkg::RT_SIGNATURE16: begin
        nxt16 = {cur16[14:0], ^(cur16 & scan_ops_pkg::POLY16)} ^ {8'h00, pin_s}; // R16
        run_d[15:0] = nxt16;
      end
      default: begin
        run_d[OL-1:IL] = {in8[6:0], ^(in8 & scan_ops_pkg::POLY8)} ^ pin_s; // R18 R22
        run_d[OL+7:OL] = {out8[6:0], ^(out8 & scan_ops_pkg::POLY8)}; // R19
      end
    endcase
  end

  // shift stages: capture, shift, run-test on rising test clock
  logic bus_wr_br;
  assign bus_wr_br = avs_write && !avs_waitrequest && (avs_address == scan_ops_pkg::ADDR_BR);
  always_ff @(posedge clk) begin
    if (srst) begin
      shift_q <= scan_ops_pkg::BR_RESET;
    end else if (bus_wr_br) begin
      shift_q <= avs_writedata[W-1:0];
    end else if (rise) begin
      if (sel_br && cap_s) begin
        if (op == scan_ops_pkg::OP_CELL_TEST) begin
          shift_q <= ~shadow_q; // R2
        end
      end else if (sel_br && sh_s) begin
        shift_q <= {tdi_s, shift_q[W-1:1]};
      end else if (active) begin
        shift_q <= run_d; // R9
      end else if (is_toggle && idle_s) begin
        shift_q[OL+7:OL] <= ~shift_q[OL+7:OL]; // R4 R5
      end
    end
  end

  // shadow latches update on falling test clock
  always_ff @(posedge clk) begin
    if (srst) begin
      shadow_q <= scan_ops_pkg::BR_RESET;
    end else if (fall) begin
      if (sel_br && upd_s && op != scan_ops_pkg::OP_CELL_TEST) begin
        shadow_q <= shift_q;
      end else if (active) begin
        if (ctrl_q != scan_ops_pkg::RT_SIGNATURE16) begin
          shadow_q[15:0] <= shift_q[15:0]; // R14 R19
        end else begin
          shadow_q[OL-1:IL] <= shift_q[OL-1:IL]; // R16 R17
        end
      end else if (is_toggle && idle_s) begin
        shadow_q[OL+7:OL] <= shift_q[OL+7:OL]; // R4
      end
    end
  end

  // control register and bypass
  always_ff @(posedge clk) begin
    if (srst) begin
      ctrl_q <= scan_ops_pkg::CR_RESET;
      bypass_q <= 1'b0;
    end else if (avs_write && !avs_waitrequest && avs_address == scan_ops_pkg::ADDR_CR) begin
      ctrl_q <= avs_writedata[1:0]; // R7
    end else if (rise) begin
      if (sel_cr && sh_s) begin
        ctrl_q <= {tdi_s, ctrl_q[1]}; // R6 capture leaves it alone
      end
      if (!sel_br && !sel_cr && cap_s) begin
        bypass_q <= 1'b0; // R3 R20
      end else if (!sel_br && !sel_cr && sh_s) begin
        bypass_q <= tdi_s;
      end
    end
  end

  // instruction register loaded by software
  always_ff @(posedge clk) begin
    if (srst) begin
      instr_q <= scan_ops_pkg::IR_RESET;
    end else if (avs_write && !avs_waitrequest && avs_address == scan_ops_pkg::ADDR_IR) begin
      instr_q <= avs_writedata[7:0];
    end
  end

  // test data output changes on falling edge; pins follow shadows in test mode, synchronised inputs otherwise
  logic tm;
  assign tm = is_run || is_toggle || (op == scan_ops_pkg::OP_READ_TEST) ||
              (op == scan_ops_pkg::OP_CTRL_TEST); // R5 R20
  always_ff @(posedge clk) begin
    if (srst) begin
      tdo <= 1'b0;
      data_out <= 8'h00;
      data_out_oe <= 1'b0;
      core_in <= 8'h00;
      test_mode <= 1'b0;
    end else begin
      test_mode <= tm;
      if (tm) begin
        data_out <= shadow_q[OL+7:OL];
        data_out_oe <= ~shadow_q[scan_ops_pkg::OE_BIT]; // R11
        core_in <= shadow_q[OL-1:IL];
      end else begin
        data_out <= pin_s;
        data_out_oe <= 1'b1;
        core_in <= pin_s;
      end
      if (fall) begin
        tdo <= sel_br ? shift_q[0] : (sel_cr ? ctrl_q[0] : bypass_q); // R21
      end
    end
  end

  // avalon slave: one wait cycle per access
  logic wait_q;
  always_ff @(posedge clk) begin
    if (srst) begin
      wait_q <= 1'b1;
    end else if ((avs_read || avs_write) && wait_q) begin
      wait_q <= 1'b0;
    end else begin
      wait_q <= 1'b1;
    end
  end
  assign avs_waitrequest = wait_q;
  always_ff @(posedge clk) begin
    if (srst) begin
      avs_readdata <= 32'h00000000;
    end else if (avs_read && wait_q) begin
      if (avs_address == scan_ops_pkg::ADDR_IR) begin
        avs_readdata <= {24'h000000, instr_q};
      end else if (avs_address == scan_ops_pkg::ADDR_CR) begin
        avs_readdata <= {30'h00000000, ctrl_q};
      end else if (avs_address == scan_ops_pkg::ADDR_BR) begin
        avs_readdata <= {14'h0000, shift_q};
      end else if (avs_address == scan_ops_pkg::ADDR_STATUS) begin
        avs_readdata <= {14'h0000, shadow_q};
      end else begin
        avs_readdata <= 32'h00000000;
      end
    end
  end

  hold_outside_a: assert property (@(posedge clk) disable iff (srst) // R23
    (rise && !idle_s && !cap_s && !sh_s && !bus_wr_br) |=> $stable(shift_q))
    else $error("shift stages moved outside idle");
  ctrl_bits_a: assert property (@(posedge clk) disable iff (srst) // R10
    (rise && active && !bus_wr_br) |=> shift_q[17:16] == $past(shift_q[17:16]))
    else $error("control cells changed in run test");
  self_test_a: assert property (@(posedge clk) disable iff (srst) // R2
    (rise && cap_s && op == scan_ops_pkg::OP_CELL_TEST && !bus_wr_br) |=>
    shift_q == ~$past(shadow_q))
    else $error("self test capture wrong");
  read_keep_a: assert property (@(posedge clk) disable iff (srst) // R1
    (rise && cap_s && sel_br && op != scan_ops_pkg::OP_CELL_TEST && !bus_wr_br) |=>
    $stable(shift_q))
    else $error("boundary read altered register");
  bypass_zero_a: assert property (@(posedge clk) disable iff (srst) // R3
    (rise && cap_s && is_toggle && !avs_write) |=> !bypass_q)
    else $error("bypass did not capture zero");
  toggle_out_a: assert property (@(posedge clk) disable iff (srst) // R4
    (rise && is_toggle && idle_s && !cap_s && !sh_s && !bus_wr_br) |=>
    shift_q[15:8] == ~$past(shift_q[15:8]) && $stable(shift_q[7:0]))
    else $error("toggle outputs wrong");
  sig_hold_a: assert property (@(posedge clk) disable iff (srst) // R17
    (fall && active && ctrl_q == scan_ops_pkg::RT_SIGNATURE16 && !sel_br) |=>
    $stable(shadow_q[15:8]))
    else $error("output shadows changed in signature mode");
  oe_gate_a: assert property (@(posedge clk) disable iff (srst) // R11
    (tm && $stable(tm)) |=> data_out_oe == !$past(shadow_q[16]))
    else $error("output enable not from cell");
  sample_in_a: assert property (@(posedge clk) disable iff (srst) // R12
    (rise && active && ctrl_q == scan_ops_pkg::RT_SAMPLE_TOGGLE && !bus_wr_br) |=>
    shift_q[7:0] == $past(pin_s))
    else $error("inputs not sampled");
  run_c: cover property (@(posedge clk) rise && active);
  comb_c: cover property (@(posedge clk) rise && active && ctrl_q == scan_ops_pkg::RT_COMBINED8);
  tog_c: cover property (@(posedge clk) fall && is_toggle && idle_s);
  pat_c: cover property (@(posedge clk) rise && active && ctrl_q == scan_ops_pkg::RT_PATTERN16);
  sig_c: cover property (@(posedge clk) rise && active && ctrl_q == scan_ops_pkg::RT_SIGNATURE16);
  pattern_step_a: assert property (@(posedge clk) disable iff (srst) // R14
    (rise && active && ctrl_q == scan_ops_pkg::RT_PATTERN16 && !bus_wr_br) |=>
    shift_q[15:0] == {$past(shift_q[14:0]), ^($past(shift_q[15:0]) & scan_ops_pkg::POLY16)})
    else $error("pattern step wrong");
  sig_step_a: assert property (@(posedge clk) disable iff (srst) // R16
    (rise && active && ctrl_q == scan_ops_pkg::RT_SIGNATURE16 && !bus_wr_br) |=>
    shift_q[15:0] == ({$past(shift_q[14:0]), ^($past(shift_q[15:0]) & scan_ops_pkg::POLY16)} ^
    {8'h00, $past(pin_s)}))
    else $error("signature step wrong");
  comb_step_a: assert property (@(posedge clk) disable iff (srst) // R18 R19
    (rise && active && ctrl_q == scan_ops_pkg::RT_COMBINED8 && !bus_wr_br) |=>
    shift_q[15:8] == {$past(shift_q[14:8]), ^($past(shift_q[15:8]) & scan_ops_pkg::POLY8)} &&
    shift_q[7:0] == ({$past(shift_q[6:0]), ^($past(shift_q[7:0]) & scan_ops_pkg::POLY8)} ^
    $past(pin_s)))
    else $error("combined step wrong");
  sample_out_a: assert property (@(posedge clk) disable iff (srst) // R13
    (rise && active && ctrl_q == scan_ops_pkg::RT_SAMPLE_TOGGLE && !bus_wr_br) |=>
    shift_q[15:8] == ~$past(shift_q[15:8]))
    else $error("outputs not toggled in sample mode");
  tdo_fall_a: assert property (@(posedge clk) disable iff (srst) // R21
    !fall |=> $stable(tdo))
    else $error("test data output moved off falling edge");
  mode_level_a: assert property (@(posedge clk) disable iff (srst) // R5 R20
    1'b1 |=> test_mode == $past(tm))
    else $error("test mode level wrong");
endmodule

// [include/scan_ops_pkg.sv]
package scan_ops_pkg;
  // boundary register layout: [7:0] input cells, [15:8] output cells, 16 output enable, 17 latch enable
  localparam int unsigned BR_WIDTH = 18;
  localparam int unsigned IN_LSB = 0;
  localparam int unsigned OUT_LSB = 8;
  localparam int unsigned OE_BIT = 16;
  localparam int unsigned LE_BIT = 17;
  localparam int unsigned CR_WIDTH = 2;
  localparam int unsigned IR_WIDTH = 8;
  localparam logic [6:0] OP_RUN_TEST = 7'h09;
  localparam logic [6:0] OP_READ_NORMAL = 7'h0a;
  localparam logic [6:0] OP_READ_TEST = 7'h0b;
  localparam logic [6:0] OP_CELL_TEST = 7'h0c;
  localparam logic [6:0] OP_TOGGLE = 7'h0d;
  localparam logic [6:0] OP_CTRL_NORMAL = 7'h0e;
  localparam logic [6:0] OP_CTRL_TEST = 7'h0f;
  localparam logic [1:0] RT_SAMPLE_TOGGLE = 2'h0;
  localparam logic [1:0] RT_PATTERN16 = 2'h1;
  localparam logic [1:0] RT_SIGNATURE16 = 2'h2;
  localparam logic [1:0] RT_COMBINED8 = 2'h3;
  // maximal-length feedback: x^16+x^14+x^13+x^11+1 and x^8+x^6+x^5+x^4+1
  localparam logic [15:0] POLY16 = 16'hb400;
  localparam logic [7:0] POLY8 = 8'hb8;
  localparam logic [BR_WIDTH-1:0] BR_RESET = 18'h00000;
  localparam logic [CR_WIDTH-1:0] CR_RESET = 2'h0;
  localparam logic [IR_WIDTH-1:0] IR_RESET = 8'h81;
  // register bus
  localparam logic [3:0] ADDR_IR = 4'h0;
  localparam logic [3:0] ADDR_CR = 4'h4;
  localparam logic [3:0] ADDR_BR = 4'h8;
  localparam logic [3:0] ADDR_STATUS = 4'hc;
endpackage

// [verif/tap_controller_model.sv]
`timescale 1ns/1ps
module tap_controller_model (
  input wire logic clk,
  output logic tck,
  output logic tdi,
  output logic capture_dr,
  output logic shift_dr,
  output logic update_dr,
  output logic run_idle
);
  initial begin
    tck = 1'b0;
    tdi = 1'b0;
    capture_dr = 1'b0;
    shift_dr = 1'b0;
    update_dr = 1'b0;
    run_idle = 1'b0;
  end
  // n test-clock cycles of 8 clk; levels and tdi change only while tck is low
  task automatic cycles(input int n, input logic [3:0] lv, input logic din);
    @(posedge clk);
    {capture_dr, shift_dr, update_dr, run_idle} <= lv;
    tdi <= din;
    repeat (4) @(posedge clk);
    for (int i = 0; i < n; i++) begin
      tck <= 1'b1;
      repeat (4) @(posedge clk);
      tck <= 1'b0;
      repeat (4) @(posedge clk);
    end
    {capture_dr, shift_dr, update_dr, run_idle} <= 4'h0;
    // released data line shows the inverse, not the last value
    tdi <= ~din;
    repeat (8) @(posedge clk);
  endtask
endmodule

// [verif/test_boundary_scan_test_ops.sv]
`timescale 1ns/1ps
module test_boundary_scan_test_ops;
  logic clk, srst, tck, tdi, capture_dr, shift_dr, update_dr, run_idle;
  logic avs_read, avs_write, avs_waitrequest, tdo, data_out_oe, test_mode;
  logic [7:0] data_in, data_out, core_in, held;
  logic [3:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, rd;
  logic [17:0] s;
  int num_errors = 0;
  int comparisons = 0;
  initial clk = 1'b0;
  always #25 clk = ~clk;
  tap_controller_model u_tap_controller_model (.clk, .tck, .tdi, .capture_dr, .shift_dr,
    .update_dr, .run_idle);
  boundary_scan_test_ops u_boundary_scan_test_ops (.clk, .srst, .tck, .tdi, .data_in,
    .capture_dr, .shift_dr, .update_dr, .run_idle, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_readdata, .avs_waitrequest, .tdo, .data_out, .data_out_oe,
    .core_in, .test_mode);
  task automatic end_of_test;
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic bus(input logic wr, input logic [3:0] addr, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge clk);
    avs_read <= ~wr;
    avs_write <= wr;
    avs_address <= addr;
    avs_writedata <= wd;
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (avs_waitrequest !== 1'b0) begin
      num_errors++;
      end_of_test();
    end
  endtask
  task automatic rdchk(input string what, input logic [3:0] addr, input logic [31:0] exp);
    bus(1'b0, addr, 32'h0);
    check(what, rd, exp);
  endtask
  task automatic ir(input logic [6:0] op);
    bus(1'b1, scan_ops_pkg::ADDR_IR, {25'h0, op});
  endtask
  function automatic logic [17:0] step(input logic [17:0] v, input int m, input logic [7:0] d);
    logic [15:0] w;
    w = v[15:0];
    case (m[1:0])
      scan_ops_pkg::RT_SAMPLE_TOGGLE: w = {~w[15:8], d};
      scan_ops_pkg::RT_PATTERN16: w = {w[14:0], ^(w & scan_ops_pkg::POLY16)};
      scan_ops_pkg::RT_SIGNATURE16: w = {w[14:0], ^(w & scan_ops_pkg::POLY16)} ^ {8'h0, d};
      default: w = {w[14:8], ^(w[15:8] & scan_ops_pkg::POLY8), w[6:0],
        ^(w[7:0] & scan_ops_pkg::POLY8)} ^ {8'h0, d};
    endcase
    return {v[17:16], w};
  endfunction
  initial begin
    srst = 1'b1;
    data_in = 8'h00;
    avs_address = 4'h0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    repeat (5) @(posedge clk);
    srst <= 1'b0;
    rdchk("ir reset", scan_ops_pkg::ADDR_IR, 32'h81);
    rdchk("cr reset", scan_ops_pkg::ADDR_CR, 32'h0);
    rdchk("br reset", scan_ops_pkg::ADDR_BR, 32'h0);
    rdchk("unmapped", 4'h2, 32'h0);
    ir(scan_ops_pkg::OP_READ_TEST);
    bus(1'b1, scan_ops_pkg::ADDR_BR, 32'h2a5c3);
    u_tap_controller_model.cycles(1, 4'h8, 1'b0);
    u_tap_controller_model.cycles(3, 4'h1, 1'b0);
    rdchk("read capture", scan_ops_pkg::ADDR_BR, 32'h2a5c3);
    u_tap_controller_model.cycles(1, 4'h4, 1'b1);
    rdchk("read shift", scan_ops_pkg::ADDR_BR, 32'h352e1);
    u_tap_controller_model.cycles(1, 4'h2, 1'b0);
    rdchk("read update", scan_ops_pkg::ADDR_STATUS, 32'h352e1);
    ir(scan_ops_pkg::OP_CELL_TEST);
    bus(1'b1, scan_ops_pkg::ADDR_BR, 32'h2a5c3);
    u_tap_controller_model.cycles(1, 4'h8, 1'b0);
    rdchk("self test", scan_ops_pkg::ADDR_BR, 32'h0ad1e);
    check("self test mode", {31'h0, test_mode}, 32'h0);
    ir(scan_ops_pkg::OP_CTRL_NORMAL);
    bus(1'b1, scan_ops_pkg::ADDR_CR, 32'h2);
    u_tap_controller_model.cycles(1, 4'h8, 1'b0);
    rdchk("ctrl capture", scan_ops_pkg::ADDR_CR, 32'h2);
    ir(scan_ops_pkg::OP_CTRL_TEST);
    u_tap_controller_model.cycles(1, 4'h4, 1'b0);
    rdchk("ctrl shift", scan_ops_pkg::ADDR_CR, 32'h1);
    check("ctrl tdo", {31'h0, tdo}, 32'h1);
    ir(scan_ops_pkg::OP_TOGGLE);
    u_tap_controller_model.cycles(1, 4'h4, 1'b1);
    check("bypass shifted", {31'h0, tdo}, 32'h1);
    u_tap_controller_model.cycles(1, 4'h8, 1'b0);
    check("bypass capture", {31'h0, tdo}, 32'h0);
    bus(1'b1, scan_ops_pkg::ADDR_BR, 32'h05ac3);
    data_in <= 8'h3c;
    u_tap_controller_model.cycles(3, 4'h1, 1'b0);
    rdchk("toggle stages", scan_ops_pkg::ADDR_BR, 32'h0a5c3);
    check("toggle pins", {24'h0, data_out}, 32'ha5);
    check("toggle mode", {31'h0, test_mode}, 32'h1);
    check("toggle core", {24'h0, core_in}, 32'he1);
    for (int m = 0; m < 4; m++) begin
      s = {1'b0, m[0], 16'hc3a5};
      data_in <= 8'h6d ^ m[7:0];
      ir(scan_ops_pkg::OP_READ_NORMAL);
      bus(1'b1, scan_ops_pkg::ADDR_BR, {14'h0, s});
      u_tap_controller_model.cycles(1, 4'h2, 1'b0);
      ir(scan_ops_pkg::OP_RUN_TEST);
      bus(1'b1, scan_ops_pkg::ADDR_CR, 32'(m));
      u_tap_controller_model.cycles(2, 4'h0, 1'b0);
      rdchk("run held", scan_ops_pkg::ADDR_BR, {14'h0, s});
      held = data_out;
      u_tap_controller_model.cycles(5, 4'h1, 1'b0);
      repeat (5) s = step(s, m, data_in);
      rdchk("run stages", scan_ops_pkg::ADDR_BR, {14'h0, s});
      check("run oe", {31'h0, data_out_oe}, {31'h0, ~s[16]});
      check("run mode", {31'h0, test_mode}, 32'h1);
      check("run core", {24'h0, core_in}, {24'h0, s[7:0]});
      if (m == 2) begin
        check("sig pins", {24'h0, data_out}, {24'h0, held});
      end else begin
        check("run pins", {24'h0, data_out}, {24'h0, s[15:8]});
      end
    end
    end_of_test();
  end
endmodule
